/* rtl/ssr_decode.sv */
// Purpose: address decode of the sram, peripheral and flash windows
// Assumes: full 32-bit byte address
// Notes: purely combinational
`timescale 1ns/10ps
`include "ssr_map.svh"
module ssr_decode (
  // address in
  input wire logic [31:0] addr_in,
  // decoded hits
  output ssr_pkg::ssr_hit_t hit_out
);
  // window compares on inclusive bounds
  always_comb
  begin
    hit_out.sram = (addr_in >= `SSR_SRAM_BASE) &&
                   (addr_in <= `SSR_SRAM_LAST);
    hit_out.peri = (addr_in >= `SSR_PERI_BASE) &&
                   (addr_in <= `SSR_PERI_LAST);
    hit_out.flash = ((addr_in >= `SSR_FLASH_A_BASE) &&
                     (addr_in <= `SSR_FLASH_A_LAST)) ||
                    ((addr_in >= `SSR_FLASH_B_BASE) &&
                     (addr_in <= `SSR_FLASH_B_LAST));
  end
endmodule

/* rtl/ssr_map.svh */
// Purpose: offsets, windows and reset values for the standby sram block
// Assumes: 32-bit byte addresses on the system bus side
// Notes: included by ssr_decode and ssr_top; the package and ssr_parity do not include it
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_SRAM_BASE 32'h2800_0000
`define SSR_SRAM_LAST 32'h2800_03FF
`define SSR_SRAM_WORDS 256
`define SSR_WORD_IDX_MSB 9
`define SSR_WORD_IDX_LSB 2
`define SSR_PERI_BASE 32'h4000_0000
`define SSR_PERI_LAST 32'h400F_FFFF
`define SSR_FLASH_A_BASE 32'h407E_0000
`define SSR_FLASH_A_LAST 32'h407E_FFFF
`define SSR_FLASH_B_BASE 32'h407F_C000
`define SSR_FLASH_B_LAST 32'h407F_FFFF
`define SSR_CUT_LSB 0
`define SSR_CUT_MSB 1
`define SSR_CUT_KEEP 2'h0
`define SSR_CUT_RESET 2'h0
`endif

/* rtl/ssr_parity.sv */
// Purpose: even parity over the bytes of one word
// Assumes: four byte lanes
// Notes: one parity bit per byte, shared by write and read paths
`timescale 1ns/10ps
module ssr_parity (
  // data word
  input wire logic [31:0] data_in,
  // one parity bit per byte
  output logic [3:0] par_out
);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      par_out[i] = ^data_in[i*8 +: 8];
  end
endmodule

/* rtl/ssr_pkg.sv */
// Purpose: shared types for the standby sram block
// Assumes: constants come from ssr_map.svh
// Notes: no constants here beyond types
package ssr_pkg;
  // system bus request from the master
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [3:0] strb;
    logic [31:0] wdata;
    logic secure;
    logic priv;
  } ssr_req_t;
  // answer back to the master
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
    logic error;
  } ssr_rsp_t;
  // which decoded region a request falls in
  typedef struct packed {
    logic sram;
    logic peri;
    logic flash;
  } ssr_hit_t;
  // security attributes of the sram region
  typedef struct packed {
    logic sec_only;
    logic priv_only;
    logic no_write;
  } ssr_attr_t;
endpackage

/* rtl/ssr_top.sv */
// Purpose: standby sram with parity, module stop, filter and retention
// Assumes: clk_in is the peripheral bus b clock at 125 MHz
// Notes: every answer comes two edges after its request; requests outside
//        the window get no answer, refused ones inside it answer with error;
//        the array has no reset, so retained data survives a reset as well
//
// Overview of operation
// - 1 KB memory at 0x2800_0000..0x2800_03FF; other addresses ignored.
// - memory contents survive deep software standby only when the power cut field is 00b.
// - two-bit power cut field, bits 1:0, controls standby power.
// - field value 00b keeps memory powered and data retained.
// - memory and access logic run on the peripheral bus b clock.
// - one even parity bit stored per byte, checked on read.
// - software module stop refuses memory accesses with error; the clock keeps running.
// - access allowed only when the filter attributes permit it.
// - peripheral registers decoded at 4000_0000h..400F_FFFFh always.
// - flash registers decoded at 407E_0000h.. and 407F_C000h.. regions.
`timescale 1ns/10ps
`include "ssr_map.svh"
module ssr_top (
  // clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // bus side
  input ssr_pkg::ssr_req_t req_in,
  output ssr_pkg::ssr_rsp_t rsp_out,
  // decoded peripheral and flash selects
  output logic peri_sel_out,
  output logic flash_sel_out,
  // low power control
  input wire logic module_stop_in,
  input wire logic [1:0] deep_power_cut_field_in,
  input wire logic deep_standby_in,
  output logic sram_power_on_out,
  output logic retained_out,
  // security filter attributes
  input ssr_pkg::ssr_attr_t attr_in,
  // parity error status
  input wire logic par_err_clr_in,
  output logic par_err_out
);

  ////////////////////////////////////////////////////////////////////
  // decode and parity helpers
  ssr_pkg::ssr_hit_t hit;
  logic [3:0] wpar;
  logic [3:0] rpar_calc;
  logic [31:0] mem_rdata;
  logic [3:0] mem_rpar;

  // window decode of the raw request address
  ssr_decode u_dec (
    .addr_in(req_in.addr),
    .hit_out(hit)
  );

  // parity of the incoming write data
  ssr_parity u_wpar (
    .data_in(req_in.wdata),
    .par_out(wpar)
  );

  // parity recomputed from the word read back
  ssr_parity u_rpar (
    .data_in(mem_rdata),
    .par_out(rpar_calc)
  );

  ////////////////////////////////////////////////////////////////////
  // power and retention state
  logic [1:0] cut_field;
  logic [1:0] next_cut_field;
  logic power_on;
  logic next_power_on;
  logic lost;
  logic next_lost;
  logic allowed;
  logic active;
  logic sram_ok;

  // field is latched as standby is entered; leaving standby restores power
  // a cut supply leaves the contents suspect until software writes again
  always_comb
  begin
    next_cut_field = cut_field;
    next_power_on = power_on;
    next_lost = lost;
    if (!deep_standby_in)
      next_cut_field = deep_power_cut_field_in[`SSR_CUT_MSB:`SSR_CUT_LSB];
    if (deep_standby_in)
    begin
      next_power_on = (cut_field == `SSR_CUT_KEEP);
      if (cut_field != `SSR_CUT_KEEP)
        next_lost = 1'b1;
    end
    else
    begin
      next_power_on = 1'b1;
    end
    // only a write that lands in the array makes the contents valid again;
    // a refused or out of window write must not hide the loss
    if (sram_ok && req_in.write)
      next_lost = 1'b0;
  end

  // reset leaves the supply on and the field at keep
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cut_field <= `SSR_CUT_RESET;
      power_on <= 1'b1;
      lost <= 1'b0;
    end
    else if (ce_in)
    begin
      cut_field <= next_cut_field;
      power_on <= next_power_on;
      lost <= next_lost;
    end
  end

  // status straight from the power flops
  assign sram_power_on_out = power_on;
  assign retained_out = !lost;

  ////////////////////////////////////////////////////////////////////
  // access qualification
  // standby and a cut supply refuse access just as module stop does

  always_comb
  begin
    allowed = (!attr_in.sec_only || req_in.secure) &&
              (!attr_in.priv_only || req_in.priv) &&
              (!attr_in.no_write || !req_in.write);
    active = ce_in && !module_stop_in && !deep_standby_in && power_on;
    sram_ok = req_in.valid && hit.sram && allowed && active;
  end

  ////////////////////////////////////////////////////////////////////
  // memory array, data plus parity per byte
  logic [7:0] mem_data [0:`SSR_SRAM_WORDS-1][0:3];
  logic mem_par [0:`SSR_SRAM_WORDS-1][0:3];
  logic [7:0] idx;

  // word index drops the byte offset within the word
  assign idx = req_in.addr[`SSR_WORD_IDX_MSB:`SSR_WORD_IDX_LSB];

  // the read stage feeds both the answer and the parity check
  // no reset on the array so contents are retained
  // array on the bus b clock, accesses gated by module stop
  always_ff @(posedge clk_in)
  begin
    if (sram_ok && req_in.write)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (req_in.strb[b])
        begin
          mem_data[idx][b] <= req_in.wdata[b*8 +: 8];
          mem_par[idx][b] <= wpar[b];
        end
      end
    end
    if (sram_ok && !req_in.write)
    begin
      for (int b = 0; b < 4; b++)
      begin
        mem_rdata[b*8 +: 8] <= mem_data[idx][b];
        mem_rpar[b] <= mem_par[idx][b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // response pipeline
  // all answers share one latency, so a read answer and the write ack
  // of the next request can never meet in one cycle
  logic rd_pend;
  logic next_rd_pend;
  logic ack_pend;
  logic next_ack_pend;
  logic err_pend;
  logic next_err_pend;
  ssr_pkg::ssr_rsp_t rsp;
  ssr_pkg::ssr_rsp_t next_rsp;
  logic wr_ack;
  logic err_ack;

  always_comb
  begin
    // out of window is not answered here
    next_rd_pend = sram_ok && !req_in.write;
    wr_ack = sram_ok && req_in.write;
    // refused sram access is answered with error so the master never hangs
    err_ack = ce_in && req_in.valid && hit.sram && !sram_ok;
    next_ack_pend = wr_ack || err_ack;
    next_err_pend = err_ack;
    // one request a cycle, so at most one stage holds an answer
    next_rsp.valid = ack_pend || rd_pend;
    next_rsp.error = err_pend;
    next_rsp.rdata = 32'h0000_0000;
    if (rd_pend)
    begin
      next_rsp.rdata = mem_rdata;
    end
  end

  // answer stages freeze with the rest while clock enable is low
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_pend <= 1'b0;
      ack_pend <= 1'b0;
      err_pend <= 1'b0;
      rsp <= '0;
    end
    else if (ce_in)
    begin
      rd_pend <= next_rd_pend;
      ack_pend <= next_ack_pend;
      err_pend <= next_err_pend;
      rsp <= next_rsp;
    end
  end

  // answer is a flop, never a path from the request
  assign rsp_out = rsp;

  ////////////////////////////////////////////////////////////////////
  // parity check and sticky flag
  logic par_err;
  logic next_par_err;
  logic mismatch;

  // a mismatch needs a corrupted array, so the flag is a rare event
  always_comb
  begin
    mismatch = rd_pend && (rpar_calc != mem_rpar);
    next_par_err = par_err;
    if (par_err_clr_in)
      next_par_err = 1'b0;
    if (mismatch)
      next_par_err = 1'b1;
  end

  // clock enable low freezes the flag with the rest
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      par_err <= 1'b0;
    else if (ce_in)
      par_err <= next_par_err;
  end

  // flag holds until software clears it
  assign par_err_out = par_err;

  ////////////////////////////////////////////////////////////////////
  // peripheral and flash region selects, registered
  logic peri_sel;
  logic flash_sel;
  logic next_peri_sel;
  logic next_flash_sel;

  // select pulses ignore module stop and standby on purpose
  always_comb
  begin
    next_peri_sel = req_in.valid && hit.peri;
    next_flash_sel = req_in.valid && hit.flash;
  end

  // selects registered so they follow the request by one cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      peri_sel <= 1'b0;
      flash_sel <= 1'b0;
    end
    else if (ce_in)
    begin
      peri_sel <= next_peri_sel;
      flash_sel <= next_flash_sel;
    end
  end

  // one-cycle select pulses for the register decoders
  assign peri_sel_out = peri_sel;
  assign flash_sel_out = flash_sel;
endmodule

/* verif/ssr_checker.sv */
// Purpose: port assertions for the standby sram
// Assumes: one clock, reset active high
// Notes: attached by bind at the foot
`timescale 1ns/10ps
module ssr_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // bus
  input ssr_pkg::ssr_req_t req_in,
  input ssr_pkg::ssr_rsp_t rsp_out,
  input logic peri_sel_out,
  input logic flash_sel_out,
  // power and filter
  input wire logic module_stop_in,
  input wire logic [1:0] deep_power_cut_field_in,
  input wire logic deep_standby_in,
  input logic sram_power_on_out,
  input ssr_pkg::ssr_attr_t attr_in,
  input wire logic par_err_clr_in,
  input logic par_err_out
);
  // request qualifiers
  wire v = ce_in && req_in.valid;
  wire win = req_in.addr[31:10] == 22'h0A0000;
  wire w = req_in.write;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_wr; v && win && w |=> ##1 rsp_out.valid; endproperty
  a_wr: assert property (p_wr) else $error("write unanswered");
  property p_rd; v && win && !w |=> ##1 rsp_out.valid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  // answers come two edges after their request, so look there
  property p_out; v && !win |=> ##1 !rsp_out.valid; endproperty
  a_out: assert property (p_out) else $error("answer outside");
  property p_stop;
    v && win && w && module_stop_in |=> ##1 rsp_out.error;
  endproperty
  a_stop: assert property (p_stop) else $error("stop write ok");
  property p_filt;
    v && win && w && attr_in.no_write |=> ##1 rsp_out.error;
  endproperty
  a_filt: assert property (p_filt) else $error("filter miss");
  property p_sec;
    v && win && attr_in.sec_only && !req_in.secure |=> ##1 rsp_out.error;
  endproperty
  a_sec: assert property (p_sec) else $error("secure filter miss");
  property p_peri; v && req_in.addr[31:20] == 12'h400 |=> peri_sel_out;
  endproperty
  a_peri: assert property (p_peri) else $error("peri select");
  property p_fla; v && req_in.addr[31:16] == 16'h407E |=> flash_sel_out;
  endproperty
  a_fla: assert property (p_fla) else $error("flash select");
  property p_keep;
    !deep_standby_in && deep_power_cut_field_in == 2'h0 ##1
      deep_standby_in |=> sram_power_on_out;
  endproperty
  a_keep: assert property (p_keep) else $error("power lost");
  property p_cut;
    !deep_standby_in && deep_power_cut_field_in != 2'h0 ##1
      deep_standby_in [*3] |-> !sram_power_on_out;
  endproperty
  a_cut: assert property (p_cut) else $error("power kept");
  property p_par; par_err_out && !par_err_clr_in |=> par_err_out;
  endproperty
  a_par: assert property (p_par) else $error("flag dropped");
  // main scenarios seen
  c_wr: cover property (v && win && w ##2 rsp_out.valid && !rsp_out.error);
  c_ref: cover property (rsp_out.valid && rsp_out.error);
  c_cut: cover property (!sram_power_on_out);
endmodule
bind ssr_top ssr_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .ce_in(ce_in), .req_in(req_in), .rsp_out(rsp_out),
  .peri_sel_out(peri_sel_out), .flash_sel_out(flash_sel_out),
  .module_stop_in(module_stop_in), .deep_standby_in(deep_standby_in),
  .deep_power_cut_field_in(deep_power_cut_field_in),
  .sram_power_on_out(sram_power_on_out), .attr_in(attr_in),
  .par_err_clr_in(par_err_clr_in), .par_err_out(par_err_out));

/* verif/ssr_mst.sv */
// Purpose: system bus master model
// Assumes: request taken at the next rising edge
// Notes: idle bus shows inverted write, address, strobes and data; sec and prv keep their values
`timescale 1ns/10ps
module ssr_mst (
  // clock
  input wire logic clk_in,
  // bus
  output ssr_pkg::ssr_req_t req_out,
  input ssr_pkg::ssr_rsp_t rsp_in
);
  // security attributes shown by the master, changed by the bench
  logic sec = 1'b1;
  logic prv = 1'b1;
  initial req_out = '0;
  // one request, then wait up to three cycles for the answer
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] s,
    output ssr_pkg::ssr_rsp_t r);
    int i;
    r = '0;
    @(negedge clk_in);
    req_out = '{1'b1, w, a, s, d, sec, prv};
    @(negedge clk_in);
    req_out = '{1'b0, ~w, ~a, ~s, ~d, sec, prv};
    for (i = 0; i < 3 && r.valid !== 1'b1; i++)
    begin
      if (rsp_in.valid === 1'b1)
        r = rsp_in;
      else
        @(negedge clk_in);
    end
  endtask
endmodule

/* verif/tb.sv */
// Purpose: self-checking bench for the standby sram
// Assumes: 125 MHz clock, inputs change at falling edges
// Notes: parity faults need a corrupted array, not reachable here
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] B = 32'h2800_0000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic stop = 1'b0;
  logic dsb = 1'b0;
  logic [1:0] cut = 2'h0;
  logic clr = 1'b0;
  ssr_pkg::ssr_attr_t attr = '0;
  ssr_pkg::ssr_req_t req;
  ssr_pkg::ssr_rsp_t rsp;
  ssr_pkg::ssr_rsp_t r;
  logic peri, fla, pwr, ret, perr;
  int n_fail = 0;
  int num_checks = 0;
  always #4 clk_in = ~clk_in;
  ssr_mst i_mst (.clk_in(clk_in), .req_out(req), .rsp_in(rsp));
  ssr_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .req_in(req), .rsp_out(rsp), .peri_sel_out(peri),
    .flash_sel_out(fla), .module_stop_in(stop),
    .deep_power_cut_field_in(cut), .deep_standby_in(dsb),
    .sram_power_on_out(pwr), .retained_out(ret), .attr_in(attr),
    .par_err_clr_in(clr), .par_err_out(perr));
  //////////////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus cycle, judging valid and error of the answer
  task automatic io(input logic w, input logic [31:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    i_mst.xfer(w, a, d, s, r);
    chk({30'h0, r.valid, r.error}, {30'h0, e});
  endtask
  // bus cycle outside the sram, judging the select pulses while they stand
  task automatic io_sel(input logic w, input logic [31:0] a,
    input logic [1:0] e);
    logic [1:0] s;
    fork
      io(w, a, 32'h0, 4'hF, 2'h0);
      begin
        repeat (2) @(negedge clk_in);
        s = {peri, fla};
      end
    join
    chk({30'h0, s}, {30'h0, e});
  endtask
  task close_out;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // lanes, last word, readback with parity quiet
  task t_rw;
    io(1, B, 32'h1122_3344, 4'hF, 2'h2);
    io(1, B, 32'hFFFF_AAFF, 4'h2, 2'h2);
    io(1, B + 32'h3FC, 32'h8001_7FFE, 4'hF, 2'h2);
    io(0, B, 32'h0, 4'hF, 2'h2);
    chk(r.rdata, 32'h1122_AA44);
    io(0, B + 32'h3FC, 32'h0, 4'hF, 2'h2);
    chk(r.rdata, 32'h8001_7FFE);
    chk({31'h0, perr}, 32'h0);
  endtask
  // outside the window nothing answers
  task t_win;
    io(1, B + 32'h400, 32'h0, 4'hF, 2'h0);
    io(0, B - 32'h4, 32'h0, 4'hF, 2'h0);
    io_sel(1, 32'h400F_FFFC, 2'h2);
    io_sel(0, 32'h4010_0000, 2'h0);
    io_sel(0, 32'h407F_C000, 2'h1);
    io_sel(0, 32'h407E_0000, 2'h1);
    io_sel(0, 32'h407F_BFFC, 2'h0);
  endtask
  // refused writes leave the word untouched
  task t_ref;
    @(negedge clk_in) stop = 1'b1;
    io(1, B, 32'h0, 4'hF, 2'h3);
    io_sel(0, 32'h4000_0000, 2'h2);
    @(negedge clk_in) stop = 1'b0;
    attr.no_write = 1'b1;
    io(1, B, 32'h0, 4'hF, 2'h3);
    @(negedge clk_in) attr = '0;
    io(0, B, 32'h0, 4'hF, 2'h2);
    chk(r.rdata, 32'h1122_AA44);
    attr.sec_only = 1'b1;
    i_mst.sec = 1'b0;
    io(0, B, 32'h0, 4'hF, 2'h3);
    attr.sec_only = 1'b0;
    attr.priv_only = 1'b1;
    i_mst.prv = 1'b0;
    io(1, B, 32'h0, 4'hF, 2'h3);
    i_mst.sec = 1'b1;
    i_mst.prv = 1'b1;
    io(0, B, 32'h0, 4'hF, 2'h2);
    chk(r.rdata, 32'h1122_AA44);
    attr = '0;
  endtask
  // keep then cut power through standby
  task t_ret;
    @(negedge clk_in) dsb = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({30'h0, pwr, ret}, 32'h3);
    io(0, B, 32'h0, 4'hF, 2'h3);
    io_sel(0, 32'h400F_FFFC, 2'h2);
    dsb = 1'b0;
    io(0, B, 32'h0, 4'hF, 2'h2);
    chk(r.rdata, 32'h1122_AA44);
    cut = 2'h1;
    @(negedge clk_in) dsb = 1'b1;
    repeat (4) @(negedge clk_in);
    chk({31'h0, pwr}, 32'h0);
    dsb = 1'b0;
    clr = 1'b1;
    repeat (2) @(negedge clk_in);
    clr = 1'b0;
    chk({30'h0, pwr, ret}, 32'h2);
    io(1, B, 32'h5A5A_0000, 4'hF, 2'h2);
    repeat (2) @(negedge clk_in);
    chk({31'h0, ret}, 32'h1);
  endtask
  // watchdog, far beyond the hundred or so cycles used
  initial
  begin
    #20000;
    n_fail++;
    close_out;
  end
  initial
  begin
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk({27'h0, pwr, ret, perr, peri, fla}, 32'h18);
    t_rw;
    t_win;
    t_ref;
    t_ret;
    close_out;
  end
endmodule
